// ==== inc/pms_consts.svh ====
// Constants of the power mode sequencer: timing, reset values, levels.
// Assumes a single core clock; counts are derived from its rate.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
// Core clock rate in hertz
`define PMS_CLK_HZ 125000000
// Milliseconds in a second
`define PMS_MS_PER_S 1000
// Core cycles in one millisecond
`define PMS_CYC_PER_MS (`PMS_CLK_HZ / `PMS_MS_PER_S)
// Power-up interval after ignition, in ms
`define PMS_T_PWRUP_MS 100
// Half period of the status LED flash, in ms
`define PMS_T_BLINK_MS 500
// Width of the millisecond counter
`define PMS_MS_W 10
// Function level after startup, power saving off
`define PMS_FUN_DEFAULT 4'h1
// Width of a function level
`define PMS_FUN_W 4
// Battery capacity reported in alarm mode
`define PMS_CAP_ALARM 8'h00
`endif

// ==== inc/pms_pkg.sv ====
// Types of the power mode sequencer: mode states and command codes.
// Assumes the command decoder outside delivers one code per command.
package pms_pkg;
    // Operating mode, one-hot
    typedef enum logic [4:0] {
        PMS_OFF = 5'h01, // Powered down
        PMS_PWRUP = 5'h02, // Power-up interval running
        PMS_CHG = 5'h04, // Charge-only mode
        PMS_ALM = 5'h08, // Alarm mode
        PMS_NORM = 5'h10 // Normal operation
    } pms_state_t;
    // Decoded command codes
    typedef enum logic [2:0] {
        PMS_CMD_ALARM_SET = 3'h0, // Set alarm time
        PMS_CMD_CLOCK_SET = 3'h1, // Set RTC date and time
        PMS_CMD_CHG_QUERY = 3'h2, // Charge monitor query
        PMS_CMD_TEMP_QUERY = 3'h3, // Temperature query
        PMS_CMD_POWER_DOWN = 3'h4, // Software power down
        PMS_CMD_FUN_SET = 3'h5, // Select function level
        PMS_CMD_FUN_QUERY = 3'h6, // Query function level
        PMS_CMD_OTHER = 3'h7 // Any other command
    } pms_cmd_t;
endpackage

// ==== rtl/pms_ms_tick.sv ====
// Millisecond enable divider for the power mode sequencer.
// Assumes a synchronous active-low reset already released cleanly.
`timescale 1ns/10ps
`include "pms_consts.svh"
module pms_ms_tick #(
    parameter int CYC_PER_MS = `PMS_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst_sync_n,
    output logic ms_tick_q
);
    // Counter width covers one millisecond
    localparam int CW = $clog2(CYC_PER_MS);

    // Refuse a divider that cannot count
    if (CYC_PER_MS < 2) begin : g_chk
        $error("pms_ms_tick: CYC_PER_MS must be at least 2");
    end

    logic [CW-1:0] div_q; // Cycle counter within a millisecond

    // Count cycles, wrap and pulse once per millisecond
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_q <= '0;
            ms_tick_q <= 1'b0;
        end else if (div_q == CW'(CYC_PER_MS - 1)) begin
            div_q <= '0;
            ms_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + CW'(1);
            ms_tick_q <= 1'b0;
        end
    end
endmodule // pms_ms_tick

// ==== rtl/pms_sequencer.sv ====
// Power mode sequencer: ignition power-up, charge-only and alarm
// modes, function level selection and status LED drive.
// Assumes all inputs synchronous to core_clk; battery_ok comes from
// an outside comparator against the supply threshold.
`timescale 1ns/10ps
`include "pms_consts.svh"

module pms_sequencer
    import pms_pkg::*;
#(
    parameter int CYC_PER_MS = `PMS_CYC_PER_MS,
    parameter int T_PWRUP_MS = `PMS_T_PWRUP_MS,
    parameter int T_BLINK_MS = `PMS_T_BLINK_MS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic battery_ok,
    input wire logic ignition_n,
    input wire logic charger_present,
    input wire logic rtc_alarm_due,
    input wire logic net_registered,
    input wire logic [7:0] battery_capacity,
    input wire logic cmd_valid,
    input wire pms_cmd_t cmd_code,
    input wire logic [`PMS_FUN_W-1:0] cmd_level,
    output pms_state_t mode_q,
    output logic core_power_en_q,
    output logic ready_q,
    output logic net_login_en_q,
    output logic uart_full_q,
    output logic charge_en_q,
    output logic led_on_q,
    output logic power_save_q,
    output logic [`PMS_FUN_W-1:0] fun_level_q,
    output logic alarm_armed_q,
    output logic alarm_start_notice_q,
    output logic charge_start_notice_q,
    output logic cmd_ack_q,
    output logic cmd_rej_q,
    output logic [7:0] rsp_capacity_q,
    output logic rsp_charger_q
);
    // Refuse timings the counter cannot hold
    if (T_PWRUP_MS < 1 || T_PWRUP_MS >= (1 << `PMS_MS_W) ||
        T_BLINK_MS < 1 || T_BLINK_MS >= (1 << `PMS_MS_W)) begin : g_chk
        $error("pms_sequencer: timing out of counter range");
    end

    localparam logic [`PMS_MS_W-1:0] PWRUP_LAST =
        `PMS_MS_W'(T_PWRUP_MS - 1); // Last ms of power-up
    localparam logic [`PMS_MS_W-1:0] BLINK_LAST =
        `PMS_MS_W'(T_BLINK_MS - 1); // Last ms of LED half period

    logic rst_meta_q; // Reset release, first stage
    logic rst_sync_n; // Reset release, second stage
    logic ms_tick; // One-cycle pulse each millisecond
    pms_state_t mode_d; // Next mode
    logic [`PMS_MS_W-1:0] pwrup_ms_q; // Power-up elapsed ms
    logic [`PMS_MS_W-1:0] blink_ms_q; // LED half period elapsed ms
    logic blink_q; // LED flash phase
    logic cmd_ok; // Command allowed in present mode
    logic level_ok; // Requested level is a legal one
    logic restricted; // Charge-only or alarm mode
    logic enter_norm; // Power-up interval completes now

    // Release the asynchronous reset through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Millisecond enable for all timing
    pms_ms_tick #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_tick (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .ms_tick_q(ms_tick)
    );

    // Restricted modes serve only the short command list
    assign restricted = (mode_q == PMS_CHG) || (mode_q == PMS_ALM);
    // Power-up ends on the tick that closes its last ms; a supply
    // loss in that same cycle still wins and aborts
    assign enter_norm = (mode_q == PMS_PWRUP) && ms_tick &&
        (pwrup_ms_q == PWRUP_LAST) && battery_ok;

    // Legal function levels
    always_comb begin
        unique case (cmd_level)
            4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8: level_ok = 1'b1;
            default: level_ok = 1'b0; // Unsupported level
        endcase
    end

    // Which commands each mode serves
    always_comb begin
        cmd_ok = 1'b0;
        if (mode_q == PMS_NORM) begin
            // Full command set; level set needs a legal level
            cmd_ok = (cmd_code != PMS_CMD_FUN_SET) || level_ok;
        end else if (restricted) begin
            // Only the five restricted commands
            unique case (cmd_code)
                PMS_CMD_ALARM_SET, PMS_CMD_CLOCK_SET, PMS_CMD_CHG_QUERY,
                PMS_CMD_TEMP_QUERY, PMS_CMD_POWER_DOWN:
                    cmd_ok = 1'b1;
                default: cmd_ok = 1'b0; // Refused
            endcase
        end
    end

    // Mode transitions
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PMS_OFF: begin
                // Ignition is only honoured above the supply threshold
                if (battery_ok && !ignition_n) begin
                    mode_d = PMS_PWRUP;
                end else if (rtc_alarm_due && alarm_armed_q) begin
                    mode_d = PMS_ALM;
                end else if (charger_present) begin
                    mode_d = PMS_CHG;
                end
            end
            PMS_PWRUP: begin
                // Ignition not watched; the host may still hold it
                if (!battery_ok) begin
                    mode_d = PMS_OFF;
                end else if (enter_norm) begin
                    mode_d = PMS_NORM;
                end
            end
            PMS_CHG: begin
                if (battery_ok && !ignition_n) begin
                    mode_d = PMS_PWRUP;
                end else if (!charger_present ||
                        (cmd_valid && cmd_code == PMS_CMD_POWER_DOWN)) begin
                    mode_d = PMS_OFF; // Charger gone or powered down
                end
            end
            PMS_ALM: begin
                if (battery_ok && !ignition_n) begin
                    mode_d = PMS_PWRUP;
                end else if (cmd_valid &&
                        cmd_code == PMS_CMD_POWER_DOWN) begin
                    mode_d = PMS_OFF; // Power down
                end
            end
            PMS_NORM: begin
                // Ignition has no effect once running
                if (cmd_valid && cmd_code == PMS_CMD_POWER_DOWN) begin
                    mode_d = PMS_OFF; // Software power down
                end
            end
            default: mode_d = PMS_OFF; // Illegal code recovers
        endcase
    end

    // Mode register; the enables below look at the next mode
    // so they change on the same edge as mode_q
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_q <= PMS_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Count milliseconds of the power-up interval
    // Holds at the last ms so a long stay cannot wrap
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwrup_ms_q <= '0;
        end else if (mode_q != PMS_PWRUP) begin
            pwrup_ms_q <= '0; // Restart on every entry
        end else if (ms_tick && pwrup_ms_q != PWRUP_LAST) begin
            pwrup_ms_q <= pwrup_ms_q + `PMS_MS_W'(1);
        end
    end

    // Supplies and interface enables follow the next mode
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_power_en_q <= 1'b0;
            ready_q <= 1'b0;
            net_login_en_q <= 1'b0;
            uart_full_q <= 1'b0;
        end else begin
            core_power_en_q <= (mode_d != PMS_OFF);
            ready_q <= (mode_d == PMS_NORM);
            // Network login only in normal operation
            net_login_en_q <= (mode_d == PMS_NORM);
            uart_full_q <= (mode_d == PMS_NORM);
        end
    end

    // Charging: charge-only and normal with charger, never in alarm
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            charge_en_q <= 1'b0;
        end else if (mode_d == PMS_ALM) begin
            charge_en_q <= 1'b0;
        end else begin
            charge_en_q <= charger_present &&
                (mode_d == PMS_CHG || mode_d == PMS_NORM);
        end
    end

    // Start notices, one cycle on mode entry
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alarm_start_notice_q <= 1'b0;
            charge_start_notice_q <= 1'b0;
        end else begin
            alarm_start_notice_q <= (mode_d == PMS_ALM) &&
                (mode_q != PMS_ALM);
            charge_start_notice_q <= (mode_d == PMS_CHG) &&
                (mode_q != PMS_CHG);
        end
    end

    // Alarm time kept across software power down, used once
    // Set and firing never meet: the set is refused while off,
    // and firing only happens while off
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alarm_armed_q <= 1'b0;
        end else if (cmd_valid && cmd_ok &&
                cmd_code == PMS_CMD_ALARM_SET) begin
            alarm_armed_q <= 1'b1;
        end else if (mode_q == PMS_OFF && mode_d == PMS_ALM) begin
            alarm_armed_q <= 1'b0; // Alarm consumed
        end
    end

    // Function level: default at startup, stored whenever set
    // Each entry to normal restarts at the default, so a level
    // chosen in an earlier run never carries over
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fun_level_q <= `PMS_FUN_DEFAULT;
        end else if (enter_norm) begin
            fun_level_q <= `PMS_FUN_DEFAULT;
        end else if (cmd_valid && cmd_ok &&
                cmd_code == PMS_CMD_FUN_SET) begin
            fun_level_q <= cmd_level;
        end
    end

    // Power saving only in normal mode while registered
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            power_save_q <= 1'b0;
        end else begin
            power_save_q <= (mode_q == PMS_NORM) && net_registered &&
                (fun_level_q != `PMS_FUN_DEFAULT);
        end
    end

    // Command answer: ack or refuse, with charge monitor data
    // Alarm mode hides the real capacity from the host
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmd_ack_q <= 1'b0;
            cmd_rej_q <= 1'b0;
            rsp_capacity_q <= 8'h00;
            rsp_charger_q <= 1'b0;
        end else begin
            cmd_ack_q <= cmd_valid && cmd_ok;
            cmd_rej_q <= cmd_valid && !cmd_ok;
            if (cmd_valid && cmd_ok && cmd_code == PMS_CMD_CHG_QUERY) begin
                rsp_charger_q <= charger_present;
                if (mode_q == PMS_ALM) begin
                    rsp_capacity_q <= `PMS_CAP_ALARM;
                end else begin
                    rsp_capacity_q <= battery_capacity;
                end
            end
        end
    end

    // LED flash timebase
    // Phase runs free; only the drive below is gated by mode
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blink_ms_q <= '0;
            blink_q <= 1'b0;
        end else if (ms_tick) begin
            if (blink_ms_q == BLINK_LAST) begin
                blink_ms_q <= '0;
                blink_q <= !blink_q;
            end else begin
                blink_ms_q <= blink_ms_q + `PMS_MS_W'(1);
            end
        end
    end

    // LED: off outside normal, off once power saving, else flashing
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            led_on_q <= 1'b0;
        end else if (mode_q != PMS_NORM) begin
            led_on_q <= 1'b0;
        end else if (power_save_q) begin
            led_on_q <= 1'b0;
        end else begin
            led_on_q <= blink_q;
        end
    end
endmodule // pms_sequencer

// ==== sim/pms_seq_props.sv ====
// Checker for the power mode sequencer, bound to its top module.
// Assumes inputs stay quiet until the internal reset copy is free.
`timescale 1ns/10ps
`include "pms_consts.svh"
module pms_seq_props
    import pms_pkg::*;
#(
    parameter int CYC_PER_MS = 4,
    parameter int T_PWRUP_MS = 3
) (
    input logic core_clk,
    input logic rst_n,
    input logic battery_ok,
    input logic ignition_n,
    input logic cmd_valid,
    input pms_cmd_t cmd_code,
    input logic [`PMS_FUN_W-1:0] cmd_level,
    input pms_state_t mode_q,
    input logic net_login_en_q,
    input logic uart_full_q,
    input logic charge_en_q,
    input logic led_on_q,
    input logic power_save_q,
    input logic alarm_start_notice_q,
    input logic cmd_ack_q,
    input logic cmd_rej_q,
    input logic [7:0] rsp_capacity_q
);
    // Tick phase is free, so allow one ms of slack
    localparam int PU_LO = (T_PWRUP_MS - 1) * CYC_PER_MS;
    localparam int PU_HI = T_PWRUP_MS * CYC_PER_MS + 1;
    logic [15:0] pu_cnt_q; // Cycles spent in power-up
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Count cycles while power-up runs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_q <= 16'h0000;
        end else if (mode_q == PMS_PWRUP) begin
            pu_cnt_q <= pu_cnt_q + 16'h0001;
        end else begin
            pu_cnt_q <= 16'h0000;
        end
    end
    ign_start_a: assert property (
        mode_q inside {PMS_OFF, PMS_CHG, PMS_ALM} && battery_ok
        && !ignition_n |=> mode_q == PMS_PWRUP)
        else $error("ignition did not start power-up");
    pwrup_time_a: assert property (
        mode_q == PMS_NORM && $past(mode_q) == PMS_PWRUP
        |-> pu_cnt_q >= PU_LO && pu_cnt_q <= PU_HI)
        else $error("power-up interval has wrong length");
    supply_drop_a: assert property (
        mode_q == PMS_PWRUP && !battery_ok |=> mode_q == PMS_OFF)
        else $error("supply loss did not abort power-up");
    net_access_a: assert property (
        {net_login_en_q, uart_full_q} == {2{mode_q == PMS_NORM}})
        else $error("login or full access outside normal mode");
    alarm_entry_a: assert property (
        $rose(mode_q == PMS_ALM) |-> alarm_start_notice_q
        ##1 !alarm_start_notice_q)
        else $error("alarm notice missing or too long");
    alarm_cmds_a: assert property (
        cmd_valid && mode_q == PMS_ALM && cmd_code inside
        {PMS_CMD_FUN_SET, PMS_CMD_FUN_QUERY, PMS_CMD_OTHER}
        |=> cmd_rej_q && !cmd_ack_q)
        else $error("alarm mode took a barred command");
    alarm_cap_a: assert property (
        cmd_valid && mode_q == PMS_ALM && cmd_code == PMS_CMD_CHG_QUERY
        |=> rsp_capacity_q == 8'h00)
        else $error("alarm mode reported nonzero capacity");
    alarm_nochg_a: assert property (
        mode_q == PMS_ALM && $past(mode_q) == PMS_ALM
        |-> !charge_en_q && !led_on_q)
        else $error("charging or led active in alarm mode");
    level_rej_a: assert property (
        cmd_valid && mode_q == PMS_NORM && cmd_code == PMS_CMD_FUN_SET
        && !(cmd_level inside {4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8})
        |=> cmd_rej_q)
        else $error("illegal function level accepted");
    save_led_a: assert property (
        power_save_q |=> !led_on_q)
        else $error("led still flashing during power saving");
    cover property ($rose(mode_q == PMS_NORM));
    cover property ($rose(mode_q == PMS_ALM));
    cover property ($rose(power_save_q));
endmodule // pms_seq_props

// ==== sim/pms_host_model.sv ====
// Host side model: raises the battery supply, then pulses ignition.
// Assumes the bench pulses start, and drop only during power-up.
`timescale 1ns/10ps
module pms_host_model #(
    parameter int CYC_PER_MS = 4,
    parameter int SETTLE_MS = 10,
    parameter int HOLD_MS = 100,
    parameter int HOLD_CHG_MS = 1000
) (
    input wire logic core_clk,
    input wire logic start,
    input wire logic drop,
    input wire logic charger,
    output logic battery_ok,
    output logic ignition_n
);
    logic supply_up; // Supply risen past its threshold
    logic dropped; // Supply collapsed, stays down
    assign battery_ok = supply_up && !dropped;
    // Supply collapse on request, one shot, at the bench's edge
    initial begin
        dropped = 1'b0;
        @(posedge drop);
        dropped = 1'b1;
    end
    // Ordered steps: supply, settle, ignition hold, release
    initial begin
        // Line floats before the supply rises; pull-up reads high
        supply_up = 1'b0;
        ignition_n = 1'b1;
        forever begin
            @(posedge start);
            @(negedge core_clk);
            supply_up = 1'b1;
            repeat (SETTLE_MS * CYC_PER_MS) @(negedge core_clk);
            ignition_n = 1'b0;
            // A connected charger asks for the long pulse
            repeat ((charger ? HOLD_CHG_MS : HOLD_MS) * CYC_PER_MS)
                @(negedge core_clk);
            ignition_n = 1'b1;
        end
    end
endmodule // pms_host_model

// ==== sim/power_mode_sequencer_tb_top.sv ====
// Bench for the power mode sequencer with a host model.
// Assumes short sim counts: 4 cycles a ms, 3 ms power-up.
`timescale 1ns/10ps
`include "pms_consts.svh"
module power_mode_sequencer_tb_top
    import pms_pkg::*;
;
    logic core_clk, rst_n, battery_ok, ignition_n, charger_present;
    logic rtc_alarm_due, net_registered, cmd_valid, host_start, host_drop;
    logic core_power_en_q, ready_q, net_login_en_q, uart_full_q;
    logic charge_en_q, led_on_q, power_save_q, alarm_armed_q;
    logic alarm_start_notice_q, charge_start_notice_q, cmd_ack_q;
    logic cmd_rej_q, rsp_charger_q;
    logic [7:0] battery_capacity, rsp_capacity_q;
    logic [3:0] cmd_level, fun_level_q;
    pms_cmd_t cmd_code;
    pms_state_t mode_q;
    int n_fail, checks;
    logic [3:0] lv[6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h1};
    pms_sequencer #(.CYC_PER_MS(4), .T_PWRUP_MS(3), .T_BLINK_MS(2)) uut (
        .core_clk, .rst_n, .battery_ok, .ignition_n, .charger_present,
        .rtc_alarm_due, .net_registered, .battery_capacity, .cmd_valid,
        .cmd_code, .cmd_level, .mode_q, .core_power_en_q, .ready_q,
        .net_login_en_q, .uart_full_q, .charge_en_q, .led_on_q,
        .power_save_q, .fun_level_q, .alarm_armed_q, .alarm_start_notice_q,
        .charge_start_notice_q, .cmd_ack_q, .cmd_rej_q, .rsp_capacity_q,
        .rsp_charger_q);
    pms_host_model #(.CYC_PER_MS(4)) host (.core_clk, .start(host_start),
        .drop(host_drop), .charger(charger_present), .battery_ok,
        .ignition_n);
    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One command; answer stands in the cycle after it is taken
    task automatic cmd(pms_cmd_t c, logic [3:0] l, logic ack);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_level = l;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        chk("cmd_ack_q", ack, cmd_ack_q);
        chk("cmd_rej_q", !ack, cmd_rej_q);
    endtask
    task automatic wait_mode(pms_state_t m, int lim);
        while (mode_q !== m && lim > 0) begin
            @(posedge core_clk);
            #1;
            lim--;
        end
        chk("mode_q", m, mode_q);
    endtask
    task automatic host_go;
        @(negedge core_clk);
        host_start = 1'b1;
        @(negedge core_clk);
        host_start = 1'b0;
    endtask
    // Let the ignition pulse end before the next step
    task automatic host_done;
        for (int i = 0; i < 5000 && ignition_n !== 1'b1; i++)
            @(negedge core_clk);
        chk("ignition_n", 1, ignition_n);
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic t_charge;
        @(negedge core_clk);
        charger_present = 1'b1;
        step(1);
        chk("mode_q", PMS_CHG, mode_q);
        chk("charge_start_notice_q", 1, charge_start_notice_q);
        chk("net_login_en_q", 0, net_login_en_q);
        cmd(PMS_CMD_FUN_SET, 4'h5, 1'b0);
        cmd(PMS_CMD_ALARM_SET, 4'h0, 1'b1);
        host_go;
        wait_mode(PMS_NORM, 80);
        chk("ready_q", 1, ready_q);
        chk("fun_level_q", 1, fun_level_q);
        host_done;
    endtask
    task automatic t_norm;
        logic led_seen;
        led_seen = 1'b0;
        cmd(PMS_CMD_FUN_SET, 4'h5, 1'b1);
        chk("fun_level_q", 5, fun_level_q);
        step(2);
        chk("power_save_q", 0, power_save_q);
        // Not registered, so the LED must still flash
        for (int i = 0; i < 20; i++) begin
            step(1);
            led_seen = led_seen | led_on_q;
        end
        chk("led_on_q", 1, led_seen);
        @(negedge core_clk);
        net_registered = 1'b1;
        step(3);
        chk("power_save_q", 1, power_save_q);
        chk("led_on_q", 0, led_on_q);
        cmd(PMS_CMD_FUN_SET, 4'h2, 1'b0);
        foreach (lv[i]) cmd(PMS_CMD_FUN_SET, lv[i], 1'b1);
        step(1);
        chk("power_save_q", 0, power_save_q);
        @(negedge core_clk);
        charger_present = 1'b0;
        cmd(PMS_CMD_POWER_DOWN, 4'h0, 1'b1);
        chk("mode_q", PMS_OFF, mode_q);
        chk("alarm_armed_q", 1, alarm_armed_q);
    endtask
    task automatic t_alarm;
        @(negedge core_clk);
        rtc_alarm_due = 1'b1;
        step(1);
        chk("mode_q", PMS_ALM, mode_q);
        chk("alarm_start_notice_q", 1, alarm_start_notice_q);
        @(negedge core_clk);
        rtc_alarm_due = 1'b0;
        charger_present = 1'b1;
        step(3);
        chk("charge_en_q", 0, charge_en_q);
        chk("led_on_q", 0, led_on_q);
        chk("net_login_en_q", 0, net_login_en_q);
        cmd(PMS_CMD_CHG_QUERY, 4'h0, 1'b1);
        chk("rsp_capacity_q", 8'h00, rsp_capacity_q);
        chk("rsp_charger_q", 1, rsp_charger_q);
        for (int c = 0; c < 8; c++)
            if (c != 4) cmd(pms_cmd_t'(c), 4'h1, c < 4);
        host_go;
        wait_mode(PMS_NORM, 80);
        chk("charge_en_q", 1, charge_en_q);
        cmd(PMS_CMD_CHG_QUERY, 4'h0, 1'b1);
        chk("rsp_capacity_q", 8'h5a, rsp_capacity_q);
        host_done;
    endtask
    task automatic t_drop;
        @(negedge core_clk);
        charger_present = 1'b0;
        cmd(PMS_CMD_POWER_DOWN, 4'h0, 1'b1);
        host_go;
        wait_mode(PMS_PWRUP, 80);
        @(negedge core_clk);
        host_drop = 1'b1;
        @(negedge core_clk);
        host_drop = 1'b0;
        step(20);
        chk("mode_q", PMS_OFF, mode_q);
        chk("core_power_en_q", 0, core_power_en_q);
        host_done;
    endtask
    // Two long charger pulses dominate: about 9000 cycles, 72 us
    initial begin
        #150000;
        n_fail++;
        stop_test;
    end
    initial begin
        rst_n = 1'b0;
        {charger_present, rtc_alarm_due, net_registered} = 3'h0;
        {cmd_valid, host_start, host_drop} = 3'h0;
        battery_capacity = 8'h5a;
        cmd_code = PMS_CMD_OTHER;
        cmd_level = 4'h0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("mode_q", PMS_OFF, mode_q);
        chk("fun_level_q", 1, fun_level_q);
        cmd(PMS_CMD_CHG_QUERY, 4'h0, 1'b0);
        t_charge;
        t_norm;
        t_alarm;
        t_drop;
        stop_test;
    end
endmodule // power_mode_sequencer_tb_top
bind pms_sequencer pms_seq_props #(
    .CYC_PER_MS(CYC_PER_MS),
    .T_PWRUP_MS(T_PWRUP_MS)
) u_props (.core_clk, .rst_n, .battery_ok, .ignition_n, .cmd_valid,
    .cmd_code, .cmd_level, .mode_q, .net_login_en_q, .uart_full_q,
    .charge_en_q, .led_on_q, .power_save_q, .alarm_start_notice_q,
    .cmd_ack_q, .cmd_rej_q, .rsp_capacity_q);
